// ==== m8u_unit.sv ====
// Purpose: 8x8 unsigned multiplier with product register pair
// Assumes: core issues one multiply strobe per instruction cycle
// Notes:   product readable the cycle after the strobe
//
// Summary of operation
// - operands multiply unsigned into a 16-bit pair, high byte on top.
// - status flags pass through untouched by a multiply.
// - both product bytes are written in the cycle of the multiply.
// - one operand is the working register, the other a register operand.
// - product pair is read/write at 0xff3 and 0xff4, unset by reset.
`timescale 1ns/100ps
`default_nettype none
`include "m8u_params.svh"
module m8u_unit #(
  parameter int OP_W = 8
) (
  input  wire logic                 clock_in,         // core clock
  input  wire logic                 rst_in,           // async reset, high
  input  wire logic                 mul_strobe_in,    // multiply this cycle
  input  wire logic [7:0]           working_reg_in,   // working register
  input  wire logic [7:0]           reg_operand_in,   // named operand
  input  wire m8u_pkg::m8u_sfr_wr_t sfr_wr_in,        // byte write port
  input  wire m8u_pkg::m8u_flags_t  flags_in,         // status flags in
  output logic [7:0]                product_low_byte_out,  // low byte
  output logic [7:0]                product_high_byte_out, // high byte
  output m8u_pkg::m8u_flags_t       flags_out         // status flags out
);
  import m8u_pkg::*;

  // ========================================================
  // elaboration checks
  if (OP_W != 8) begin : g_op_w_check
    $error("operand width must be 8");
  end

  // ========================================================
  // product arithmetic
  function automatic m8u_product_t umul(input logic [7:0] a,
                                        input logic [7:0] b);
    logic [15:0] p;
    p = 16'h0000;
    p = {8'h00, a} * {8'h00, b};
    umul = p;
  endfunction

  m8u_product_t product_pair_q;
  m8u_product_t product_d;
  m8u_flags_t   flags_q;
  logic         pair_known_q;

  always_comb begin
    product_d = umul(working_reg_in, reg_operand_in);
  end

  // ========================================================
  // product register pair
  // no reset on purpose: the pair powers up undefined
  always_ff @(posedge clock_in) begin
    if (mul_strobe_in) begin
      product_pair_q <= product_d;
    end else if (sfr_wr_in.wr) begin
      if (sfr_wr_in.addr == `M8U_PRODUCT_LOW_ADDR) begin
        product_pair_q.low_byte <= sfr_wr_in.data;
      end
      if (sfr_wr_in.addr == `M8U_PRODUCT_HIGH_ADDR) begin
        product_pair_q.high_byte <= sfr_wr_in.data;
      end
    end
  end

  // ========================================================
  // flags: multiply never alters them
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_in;
    end
  end

  // ========================================================
  // check helper: pair undefined until the first multiply
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pair_known_q <= 1'b0;
    end else if (mul_strobe_in) begin
      pair_known_q <= 1'b1;
    end
  end

  always_comb begin
    product_low_byte_out  = product_pair_q.low_byte;
    product_high_byte_out = product_pair_q.high_byte;
    flags_out             = flags_q;
  end

  // ========================================================
  // checks
  sequence s_mul;
    mul_strobe_in;
  endsequence

  property p_product;
    @(posedge clock_in) disable iff (rst_in)
      s_mul |=> {product_high_byte_out, product_low_byte_out} ==
        $past(working_reg_in) * $past(reg_operand_in);
  endproperty
  a_product: assert property (p_product)
    else $error("product wrong");

  property p_flags;
    @(posedge clock_in) disable iff (rst_in)
      s_mul |=> flags_out == $past(flags_in);
  endproperty
  a_flags: assert property (p_flags)
    else $error("flags changed by multiply");

  property p_overwrite;
    @(posedge clock_in) disable iff (rst_in)
      (mul_strobe_in && sfr_wr_in.wr) |=>
        {product_high_byte_out, product_low_byte_out} ==
          $past(working_reg_in) * $past(reg_operand_in);
  endproperty
  a_overwrite: assert property (p_overwrite)
    else $error("write beat multiply");

  property p_sfr_low;
    @(posedge clock_in) disable iff (rst_in)
      (!mul_strobe_in && sfr_wr_in.wr &&
       sfr_wr_in.addr == `M8U_PRODUCT_LOW_ADDR) |=>
        product_low_byte_out == $past(sfr_wr_in.data);
  endproperty
  a_sfr_low: assert property (p_sfr_low)
    else $error("low byte write lost");

  property p_sfr_high;
    @(posedge clock_in) disable iff (rst_in)
      (!mul_strobe_in && sfr_wr_in.wr &&
       sfr_wr_in.addr == `M8U_PRODUCT_HIGH_ADDR) |=>
        product_high_byte_out == $past(sfr_wr_in.data);
  endproperty
  a_sfr_high: assert property (p_sfr_high)
    else $error("high byte write lost");

  property p_hold;
    @(posedge clock_in) disable iff (rst_in)
      (pair_known_q && !mul_strobe_in && !sfr_wr_in.wr) |=>
        $stable(product_pair_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("product changed without cause");

  property p_high_byte;
    @(posedge clock_in) disable iff (rst_in)
      s_mul |=> product_high_byte_out ==
        8'(({8'h00, $past(working_reg_in)} *
            {8'h00, $past(reg_operand_in)}) >> 8);
  endproperty
  a_high_byte: assert property (p_high_byte)
    else $error("high byte wrong");

  property p_flags_write;
    @(posedge clock_in) disable iff (rst_in)
      sfr_wr_in.wr |=> flags_out == $past(flags_in);
  endproperty
  a_flags_write: assert property (p_flags_write)
    else $error("flags disturbed");

  // ========================================================
  // byte writes: a multiply in the same cycle always wins
  sequence s_wr_low;
    !mul_strobe_in && sfr_wr_in.wr &&
      sfr_wr_in.addr == `M8U_PRODUCT_LOW_ADDR;
  endsequence

  sequence s_wr_high;
    !mul_strobe_in && sfr_wr_in.wr &&
      sfr_wr_in.addr == `M8U_PRODUCT_HIGH_ADDR;
  endsequence

  sequence s_wr_other;
    !mul_strobe_in && sfr_wr_in.wr &&
      sfr_wr_in.addr != `M8U_PRODUCT_LOW_ADDR &&
      sfr_wr_in.addr != `M8U_PRODUCT_HIGH_ADDR;
  endsequence

  property p_keep_high;
    @(posedge clock_in) disable iff (rst_in)
      s_wr_low ##0 pair_known_q |=> $stable(product_high_byte_out);
  endproperty
  a_keep_high: assert property (p_keep_high)
    else $error("low byte write touched high byte");

  property p_keep_low;
    @(posedge clock_in) disable iff (rst_in)
      s_wr_high ##0 pair_known_q |=> $stable(product_low_byte_out);
  endproperty
  a_keep_low: assert property (p_keep_low)
    else $error("high byte write touched low byte");

  property p_refused;
    @(posedge clock_in) disable iff (rst_in)
      s_wr_other ##0 pair_known_q |=> $stable(product_pair_q);
  endproperty
  a_refused: assert property (p_refused)
    else $error("foreign address write changed pair");

  property p_low_byte;
    @(posedge clock_in) disable iff (rst_in)
      s_mul |=> product_low_byte_out ==
        8'({8'h00, $past(working_reg_in)} *
           {8'h00, $past(reg_operand_in)});
  endproperty
  a_low_byte: assert property (p_low_byte)
    else $error("low byte wrong");

  // no disable here: the check is about reset itself
  property p_flags_reset;
    @(posedge clock_in) rst_in |=> flags_out == '0;
  endproperty
  a_flags_reset: assert property (p_flags_reset)
    else $error("flags not cleared by reset");
endmodule
`default_nettype wire

// ==== m8u_params.svh ====
// Purpose: constants of the 8x8 unsigned product unit
// Assumes: byte-wide special register bus inside the core
// Notes:   product pair has no defined reset content
`ifndef M8U_PARAMS_SVH
`define M8U_PARAMS_SVH
// ==========================================================
// addresses
`define M8U_PRODUCT_LOW_ADDR  12'hff3
`define M8U_PRODUCT_HIGH_ADDR 12'hff4
// ==========================================================
// field positions
`define M8U_HIGH_MSB 15
`define M8U_HIGH_LSB 8
`define M8U_LOW_MSB  7
`define M8U_LOW_LSB  0
`define M8U_ADDR_W   12
`endif

// ==== m8u_pkg.sv ====
// Purpose: types of the 8x8 unsigned product unit
// Assumes: m8u_params.svh holds the numbers
// Notes:   none
`default_nettype none
package m8u_pkg;
  typedef struct packed {
    logic [7:0] high_byte;
    logic [7:0] low_byte;
  } m8u_product_t;
  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  data;
  } m8u_sfr_wr_t;
  typedef struct packed {
    logic [7:0] status;
  } m8u_flags_t;
endpackage
`default_nettype wire

// ==== m8u_core_model.sv ====
// Purpose: core side issuing multiplies and byte writes
// Assumes: requests change on the falling clock edge
// Notes:   idle operands are inverted, never left stale
`timescale 1ns/100ps
`default_nettype none
module m8u_core_model (
  input  wire logic            clock_in,       // core clock
  output m8u_pkg::m8u_sfr_wr_t wr_out,         // byte write
  output logic                 mul_strobe_out, // multiply
  output logic [7:0]           w_out,          // working register
  output logic [7:0]           op_out          // register operand
);
  import m8u_pkg::*;
  // ==========================================================
  // requests
  initial begin
    wr_out = '0;
    mul_strobe_out = 1'b0;
    w_out = 8'h00;
    op_out = 8'h00;
  end
  task automatic mul(input logic [7:0] a, input logic [7:0] b);
    @(negedge clock_in);
    wr_out.wr = 1'b0;
    mul_strobe_out = 1'b1;
    w_out = a;
    op_out = b;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clock_in);
    mul_strobe_out = 1'b0;
    wr_out = '{1'b1, a, d};
  endtask
  // both requests in one cycle: the multiply must win
  task automatic mul_and_wr(input logic [7:0]  a,
                            input logic [7:0]  b,
                            input logic [11:0] addr,
                            input logic [7:0]  d);
    @(negedge clock_in);
    mul_strobe_out = 1'b1;
    w_out = a;
    op_out = b;
    wr_out = '{1'b1, addr, d};
  endtask
  // stale values would hide a missing capture
  task automatic idle;
    @(negedge clock_in);
    mul_strobe_out = 1'b0;
    wr_out.wr = 1'b0;
    wr_out.data = ~wr_out.data;
    w_out = ~w_out;
    op_out = ~op_out;
  endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Purpose: self-checking bench of the 8x8 product unit
// Assumes: one request per cycle, answer one cycle later
// Notes:   signed case applies the software correction
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import m8u_pkg::*;
  logic        clock_in = 1'b0;
  logic        rst_in   = 1'b1;
  logic        stb;
  logic [7:0]  w;
  logic [7:0]  op;
  logic [7:0]  lo;
  logic [7:0]  hi;
  m8u_sfr_wr_t wr;
  m8u_flags_t  fi = '0;
  m8u_flags_t  fo;
  int          failures = 0;
  int          comparisons = 0;
  always #5 clock_in = ~clock_in;
  m8u_core_model i_m8u_core_model (.clock_in(clock_in), .wr_out(wr),
    .mul_strobe_out(stb), .w_out(w), .op_out(op));
  m8u_unit i_m8u_unit (.clock_in(clock_in), .rst_in(rst_in),
    .mul_strobe_in(stb), .working_reg_in(w), .reg_operand_in(op),
    .sfr_wr_in(wr), .flags_in(fi), .product_low_byte_out(lo),
    .product_high_byte_out(hi), .flags_out(fo));
  // ==========================================================
  // checking
  task automatic chk(input string n, input logic [15:0] e, s);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_mul;
    logic [15:0] v [5] = '{16'h1234, 16'hffff, 16'h00ff, 16'h8001,
                           16'hff01};
    for (int k = 0; k < 5; k++) begin
      i_m8u_core_model.mul(v[k][15:8], v[k][7:0]);
      if (k > 0) begin
        chk("product", v[k-1][15:8] * v[k-1][7:0], {hi, lo});
        chk("flags", {8'h00, v[k-1][7:0]}, {8'h00, fo});
      end
      fi = v[k][7:0];
    end
    i_m8u_core_model.idle();
    chk("last product", 16'h00ff, {hi, lo});
    $display("test t_mul done");
  endtask
  task automatic t_pair;
    i_m8u_core_model.wr(12'hff3, 8'h55);
    i_m8u_core_model.wr(12'hff4, 8'haa);
    i_m8u_core_model.wr(12'hff5, 8'h11);
    i_m8u_core_model.idle();
    chk("written pair", 16'haa55, {hi, lo});
    i_m8u_core_model.mul(8'h03, 8'h05);
    i_m8u_core_model.idle();
    chk("overwrite", 16'h000f, {hi, lo});
    i_m8u_core_model.mul_and_wr(8'h07, 8'h09, 12'hff3, 8'hcc);
    i_m8u_core_model.idle();
    chk("multiply wins", 16'h003f, {hi, lo});
    $display("test t_pair done");
  endtask
  // both sign bits set: subtract each operand from the high byte
  task automatic t_signed;
    i_m8u_core_model.mul(8'hfe, 8'hfd);
    i_m8u_core_model.idle();
    i_m8u_core_model.wr(12'hff4, hi - 8'hfe - 8'hfd);
    i_m8u_core_model.idle();
    chk("signed", 16'h0006, {hi, lo});
    $display("test t_signed done");
  endtask
  // 16x16 from four partial products, then the sign fix of the top half
  task automatic t_wide;
    logic [15:0] a = 16'hfffe;
    logic [15:0] b = 16'hffff;
    logic [15:0] pp [4];
    logic [31:0] r;
    for (int k = 0; k < 4; k++) begin
      i_m8u_core_model.mul(a[8*k[1] +: 8], b[8*k[0] +: 8]);
      i_m8u_core_model.idle();
      pp[k] = {hi, lo};
    end
    r = 32'(pp[0]) + (32'(pp[1]) << 8) + (32'(pp[2]) << 8) +
        (32'(pp[3]) << 16);
    chk("wide low", 16'h0002, r[15:0]);
    chk("wide high", 16'hfffd, r[31:16]);
    if (a[15]) r[31:16] = r[31:16] - b;
    if (b[15]) r[31:16] = r[31:16] - a;
    chk("signed wide low", 16'h0002, r[15:0]);
    chk("signed wide high", 16'h0000, r[31:16]);
    $display("test t_wide done");
  endtask
  initial begin
    repeat (4) @(negedge clock_in);
    chk("reset flags", 16'h0000, {8'h00, fo});
    rst_in = 1'b0;
    t_mul();
    t_pair();
    t_signed();
    t_wide();
    test_done();
  end
endmodule
`default_nettype wire
